//--- inc/pmtr_pkg.sv
// page memory type resolver: constants, encodings and types
// assumes: a single 100 MHz core clock and a plain register port
package pmtr_pkg;

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    localparam int          ADDR_W       = 8;        // register address width
    localparam int          DATA_W       = 32;       // register data width
    localparam logic [7:0]  OFF_TABLE_LO = 8'h00;    // slots 0..3
    localparam logic [7:0]  OFF_TABLE_HI = 8'h04;    // slots 4..7
    localparam logic [7:0]  OFF_FEATURE  = 8'h08;    // feature query word, read only
    localparam logic [7:0]  OFF_FAULT    = 8'h0c;    // sticky fault status, write 1 to clear

    // ------------------------------------------------------------
    // slot table layout and reset value
    // ------------------------------------------------------------
    localparam int          SLOT_W       = 8;        // bits per slot
    localparam int          SLOT_N       = 8;        // slots in the table
    localparam int          SLOT_TYPE_W  = 3;        // low bits that carry the type
    localparam logic [63:0] TABLE_RESET  = 64'h0007040600070406; // wb,wt,weak uc,uc twice
    localparam int          FEATURE_BIT  = 16;       // support flag in the feature word
    localparam int          FAULT_BIT    = 0;        // write-fault flag in the fault word

    // ------------------------------------------------------------
    // table entry bit positions
    // ------------------------------------------------------------
    localparam int          POS_PWT      = 3;        // page writethrough bit
    localparam int          POS_PCD      = 4;        // page cache disable bit
    localparam int          POS_IDX_LEAF = 7;        // attribute index bit, 4 KB leaf entry
    localparam int          POS_IDX_DIR  = 12;       // attribute index bit, large directory entry

    // ------------------------------------------------------------
    // memory type encodings, slot and range register
    // ------------------------------------------------------------
    localparam logic [7:0]  T_UC         = 8'h00;    // uncacheable
    localparam logic [7:0]  T_WC         = 8'h01;    // write combining
    localparam logic [7:0]  T_WT         = 8'h04;    // writethrough
    localparam logic [7:0]  T_WP         = 8'h05;    // write protect
    localparam logic [7:0]  T_WB         = 8'h06;    // writeback
    localparam logic [7:0]  T_WEAK_UC    = 8'h07;    // weak uncacheable, slots only

    // effective memory type after the merge
    typedef enum logic [2:0] {
        EFF_UC,
        EFF_WC,
        EFF_WT,
        EFF_WP,
        EFF_WB,
        EFF_CD
    } pmtr_eff_t;

    // kind of table entry that supplied the index bits
    typedef enum logic [1:0] {
        LVL_LEAF_4K,
        LVL_LARGE_DIR,
        LVL_UPPER
    } pmtr_level_t;

endpackage

//--- hdl/pmtr_resolver.sv
// page memory type resolver: slot table, write checks, lookup and merge
// assumes: walker and cache logic share i_ref_clk; register master never
// issues read and write in the same cycle
//
// How it works
// - one 64-bit table of eight type slots
// - slot encodings 00,01,04,05,06,07 only
// - weak uncacheable acts uncacheable unless range wc
// - reserved nonzero bits fault, table unchanged
// - unsupported encoding faults; any supported encoding allowed
// - reset slots wb, wt, weak uc, uc twice
// - index is attribute bit, cache disable, writethrough
// - attribute bit at 7 leaf, 12 large
// - entries without attribute bit use zero
// - cache disable bit 4, writethrough bit 3
// - lookup always active, no disable control
// - every translated access selects and applies slot
// - upper levels index slots 0 to 3 only
// - merge for uncacheable, weak uncacheable, write combining
// - merge for write protect, writethrough, writeback
// - range registers off means range uncacheable
// - feature word bit 16 reports support
// - writethrough: shared read alloc, no write alloc
// - write protect: shared reads, writes invalidate hits
// - writeback: read alloc shared/exclusive, write alloc modified
// - uncacheable no combine or speculation; wc allows
module pmtr_resolver (
    input  wire logic                            i_ref_clk,
    input  wire logic                            i_nrst,
    input  wire logic [pmtr_pkg::ADDR_W-1:0]     i_addr,
    input  wire logic [pmtr_pkg::DATA_W-1:0]     i_wdata,
    input  wire logic                            i_wr,
    input  wire logic                            i_rd,
    output logic      [pmtr_pkg::DATA_W-1:0]     o_rdata,
    output logic                                 o_fault,
    input  wire logic                            i_xlate_valid,
    input  wire logic [63:0]                     i_entry,
    input  wire logic [1:0]                      i_level,
    input  wire logic                            i_range_en,
    input  wire logic [7:0]                      i_range_type,
    output logic                                 o_eff_valid,
    output logic      [2:0]                      o_eff_type,
    output logic      [2:0]                      o_slot_index,
    output logic                                 o_cacheable,
    output logic                                 o_rd_alloc,
    output logic                                 o_rd_alloc_excl,
    output logic                                 o_wr_alloc,
    output logic                                 o_wr_to_mem,
    output logic                                 o_wr_hit_inval,
    output logic                                 o_combine_ok,
    output logic                                 o_spec_ok
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic        rst_meta;   // first release stage
    logic        rst_n;      // released reset used everywhere

    // two stage release so every flop leaves reset on the same edge
    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------
    // write checking
    // ------------------------------------------------------------
    logic        wr_lo;      // write aimed at slots 0..3
    logic        wr_hi;      // write aimed at slots 4..7
    logic        bad_field;  // some slot of the word is illegal
    logic [3:0]  field_bad;  // per slot verdict

    assign wr_lo = i_wr && (i_addr == pmtr_pkg::OFF_TABLE_LO);
    assign wr_hi = i_wr && (i_addr == pmtr_pkg::OFF_TABLE_HI);

    // each byte of the word is one slot; check reserved bits and code
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_chk
            logic [7:0] fld;  // one slot of the incoming word
            assign fld = i_wdata[g*pmtr_pkg::SLOT_W +: pmtr_pkg::SLOT_W];
            assign field_bad[g] = (fld != pmtr_pkg::T_UC) &&
                                  (fld != pmtr_pkg::T_WC) &&
                                  (fld != pmtr_pkg::T_WT) &&
                                  (fld != pmtr_pkg::T_WP) &&
                                  (fld != pmtr_pkg::T_WB) &&
                                  (fld != pmtr_pkg::T_WEAK_UC);
        end
    endgenerate

    assign bad_field = |field_bad;

    // ------------------------------------------------------------
    // slot table
    // ------------------------------------------------------------
    logic [63:0] table_q;    // the eight slots, slot 0 in the low byte

    // a clean write replaces its half; a faulting write leaves it alone
    always_ff @(posedge i_ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            table_q <= pmtr_pkg::TABLE_RESET;
        end
        else if (wr_lo && !bad_field)
        begin
            table_q[31:0] <= i_wdata;
        end
        else if (wr_hi && !bad_field)
        begin
            table_q[63:32] <= i_wdata;
        end
    end

    a_bad_wr_hold: assert property ((wr_lo || wr_hi) && bad_field |=> $stable(table_q))
        else $error("faulting write changed the slot table");

    a_good_wr_lo: assert property (wr_lo && !bad_field |=> table_q[31:0] == $past(i_wdata))
        else $error("clean write did not reach slots 0 to 3");

    // ------------------------------------------------------------
    // fault reporting
    // ------------------------------------------------------------
    logic        fault_set;  // this cycle's write faults
    logic        fault_sticky; // latched until software clears it

    assign fault_set = (wr_lo || wr_hi) && bad_field;

    // one cycle pulse per faulting write
    always_ff @(posedge i_ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_fault <= 1'b0;
        end
        else
        begin
            o_fault <= fault_set;
        end
    end

    // sticky copy; a new fault wins over a clear in the same cycle
    always_ff @(posedge i_ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fault_sticky <= 1'b0;
        end
        else if (fault_set)
        begin
            fault_sticky <= 1'b1;
        end
        else if (i_wr && (i_addr == pmtr_pkg::OFF_FAULT) && i_wdata[pmtr_pkg::FAULT_BIT])
        begin
            fault_sticky <= 1'b0;
        end
    end

    a_fault_pulse: assert property (fault_set |=> o_fault && fault_sticky)
        else $error("faulting write not reported");

    // ------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------
    logic [31:0] next_rdata; // read word chosen by address

    // unmapped addresses read as zero
    always_comb
    begin
        next_rdata = '0;
        unique case (i_addr)
            pmtr_pkg::OFF_TABLE_LO: next_rdata = table_q[31:0];
            pmtr_pkg::OFF_TABLE_HI: next_rdata = table_q[63:32];
            pmtr_pkg::OFF_FEATURE:  next_rdata[pmtr_pkg::FEATURE_BIT] = 1'b1;
            pmtr_pkg::OFF_FAULT:    next_rdata[pmtr_pkg::FAULT_BIT] = fault_sticky;
            default:                next_rdata = '0;
        endcase
    end

    // data stands only in the cycle after the read strobe
    always_ff @(posedge i_ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_rdata <= '0;
        end
        else if (i_rd)
        begin
            o_rdata <= next_rdata;
        end
        else
        begin
            o_rdata <= '0;
        end
    end

    a_feature_read: assert property (i_rd && i_addr == pmtr_pkg::OFF_FEATURE
                                     |=> o_rdata[pmtr_pkg::FEATURE_BIT])
        else $error("feature word does not report support");

    // ------------------------------------------------------------
    // slot lookup
    // ------------------------------------------------------------
    logic        idx_attr;   // attribute index bit of this entry
    logic [2:0]  slot_idx;   // selected slot
    logic [7:0]  slot_type;  // type held in that slot
    logic [7:0]  range_type; // range type seen by the merge

    // pick the attribute bit by entry kind; upper levels have none
    always_comb
    begin
        unique case (i_level)
            pmtr_pkg::LVL_LEAF_4K:   idx_attr = i_entry[pmtr_pkg::POS_IDX_LEAF];
            pmtr_pkg::LVL_LARGE_DIR: idx_attr = i_entry[pmtr_pkg::POS_IDX_DIR];
            default:                 idx_attr = 1'b0;
        endcase
    end

    // no enable term: the lookup runs on every translation
    assign slot_idx  = {idx_attr,
                        i_entry[pmtr_pkg::POS_PCD],
                        i_entry[pmtr_pkg::POS_PWT]};
    assign slot_type = table_q[slot_idx*pmtr_pkg::SLOT_W +: pmtr_pkg::SLOT_W];
    assign range_type = i_range_en ? i_range_type : pmtr_pkg::T_UC;

    // ------------------------------------------------------------
    // merge with the range type
    // ------------------------------------------------------------
    pmtr_pkg::pmtr_eff_t next_eff;   // effective type

    // undefined pairs fall to cache disabled, the safe answer
    always_comb
    begin
        next_eff = pmtr_pkg::EFF_CD;
        unique case (slot_type)
            pmtr_pkg::T_UC:
                next_eff = (range_type == pmtr_pkg::T_UC) ? pmtr_pkg::EFF_UC : pmtr_pkg::EFF_CD;
            pmtr_pkg::T_WEAK_UC:
                if (range_type == pmtr_pkg::T_UC)
                    next_eff = pmtr_pkg::EFF_UC;
                else if (range_type == pmtr_pkg::T_WC)
                    next_eff = pmtr_pkg::EFF_WC;
                else
                    next_eff = pmtr_pkg::EFF_CD;
            pmtr_pkg::T_WC:
                next_eff = pmtr_pkg::EFF_WC;
            pmtr_pkg::T_WP:
                unique case (range_type)
                    pmtr_pkg::T_UC: next_eff = pmtr_pkg::EFF_UC;
                    pmtr_pkg::T_WP: next_eff = pmtr_pkg::EFF_WP;
                    pmtr_pkg::T_WB: next_eff = pmtr_pkg::EFF_WP;
                    default:        next_eff = pmtr_pkg::EFF_CD;
                endcase
            pmtr_pkg::T_WT:
                unique case (range_type)
                    pmtr_pkg::T_UC: next_eff = pmtr_pkg::EFF_UC;
                    pmtr_pkg::T_WT: next_eff = pmtr_pkg::EFF_WT;
                    pmtr_pkg::T_WB: next_eff = pmtr_pkg::EFF_WT;
                    default:        next_eff = pmtr_pkg::EFF_CD;
                endcase
            pmtr_pkg::T_WB:
                unique case (range_type)
                    pmtr_pkg::T_UC: next_eff = pmtr_pkg::EFF_UC;
                    pmtr_pkg::T_WC: next_eff = pmtr_pkg::EFF_WC;
                    pmtr_pkg::T_WT: next_eff = pmtr_pkg::EFF_WT;
                    pmtr_pkg::T_WP: next_eff = pmtr_pkg::EFF_WP;
                    pmtr_pkg::T_WB: next_eff = pmtr_pkg::EFF_WB;
                    default:        next_eff = pmtr_pkg::EFF_CD;
                endcase
            default:
                next_eff = pmtr_pkg::EFF_CD;
        endcase
    end

    // ------------------------------------------------------------
    // cache behaviour of the effective type
    // ------------------------------------------------------------
    logic        next_cache;     // may be cached
    logic        next_rd_alloc;  // read miss allocates
    logic        next_rd_excl;   // read allocate may take exclusive
    logic        next_wr_alloc;  // write miss allocates modified
    logic        next_wr_mem;    // writes go to main memory
    logic        next_wr_inval;  // write hit invalidates the line
    logic        next_combine;   // writes may be combined
    logic        next_spec;      // speculative reads allowed

    // uncacheable and cache-disabled forbid everything
    always_comb
    begin
        next_cache    = 1'b0;
        next_rd_alloc = 1'b0;
        next_rd_excl  = 1'b0;
        next_wr_alloc = 1'b0;
        next_wr_mem   = 1'b1;
        next_wr_inval = 1'b0;
        next_combine  = 1'b0;
        next_spec     = 1'b0;
        unique case (next_eff)
            pmtr_pkg::EFF_WC:
            begin
                next_combine = 1'b1;
                next_spec    = 1'b1;
            end
            pmtr_pkg::EFF_WT:
            begin
                next_cache    = 1'b1;
                next_rd_alloc = 1'b1;
            end
            pmtr_pkg::EFF_WP:
            begin
                next_cache    = 1'b1;
                next_rd_alloc = 1'b1;
                next_wr_inval = 1'b1;
            end
            pmtr_pkg::EFF_WB:
            begin
                next_cache    = 1'b1;
                next_rd_alloc = 1'b1;
                next_rd_excl  = 1'b1;
                next_wr_alloc = 1'b1;
                next_wr_mem   = 1'b0;
            end
            default:
            begin
                next_cache = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // result registers
    // ------------------------------------------------------------
    // valid pulses for one cycle after the translation; type and attributes held until the next
    always_ff @(posedge i_ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_eff_valid <= 1'b0;
        end
        else
        begin
            o_eff_valid <= i_xlate_valid;
        end
    end

    // type and attributes load on each translation
    always_ff @(posedge i_ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_eff_type      <= 3'h0;
            o_slot_index    <= 3'h0;
            o_cacheable     <= 1'b0;
            o_rd_alloc      <= 1'b0;
            o_rd_alloc_excl <= 1'b0;
            o_wr_alloc      <= 1'b0;
            o_wr_to_mem     <= 1'b0;
            o_wr_hit_inval  <= 1'b0;
            o_combine_ok    <= 1'b0;
            o_spec_ok       <= 1'b0;
        end
        else if (i_xlate_valid)
        begin
            o_eff_type      <= next_eff;
            o_slot_index    <= slot_idx;
            o_cacheable     <= next_cache;
            o_rd_alloc      <= next_rd_alloc;
            o_rd_alloc_excl <= next_rd_excl;
            o_wr_alloc      <= next_wr_alloc;
            o_wr_to_mem     <= next_wr_mem;
            o_wr_hit_inval  <= next_wr_inval;
            o_combine_ok    <= next_combine;
            o_spec_ok       <= next_spec;
        end
    end

    a_index_form: assert property (i_xlate_valid && i_level == pmtr_pkg::LVL_LEAF_4K
        |=> o_eff_valid && o_slot_index == {$past(i_entry[pmtr_pkg::POS_IDX_LEAF]),
                                            $past(i_entry[pmtr_pkg::POS_PCD]),
                                            $past(i_entry[pmtr_pkg::POS_PWT])})
        else $error("leaf slot index formed wrongly");

    a_upper_low: assert property (i_xlate_valid && i_level == pmtr_pkg::LVL_UPPER
                                  |=> o_slot_index[2] == 1'b0)
        else $error("upper level indexed above slot 3");

    a_range_off: assert property (i_xlate_valid && !i_range_en && slot_type == pmtr_pkg::T_WB
                                  |=> o_eff_type == pmtr_pkg::EFF_UC)
        else $error("disabled range registers not seen as uncacheable");

    a_wc_slot: assert property (i_xlate_valid && slot_type == pmtr_pkg::T_WC
                                |=> o_eff_type == pmtr_pkg::EFF_WC && o_combine_ok && !o_cacheable)
        else $error("write combining slot not kept");

    a_weak_over: assert property (i_xlate_valid && slot_type == pmtr_pkg::T_WEAK_UC
                                  && i_range_en && i_range_type == pmtr_pkg::T_WC
                                  |=> o_eff_type == pmtr_pkg::EFF_WC)
        else $error("weak uncacheable not overridden by range wc");

    a_uc_strict: assert property (o_eff_valid && o_eff_type == pmtr_pkg::EFF_UC
                                  |-> !o_spec_ok && !o_combine_ok && !o_cacheable)
        else $error("uncacheable access allowed caching or speculation");

    a_wb_alloc: assert property (o_eff_valid && o_eff_type == pmtr_pkg::EFF_WB
                                 |-> o_wr_alloc && o_rd_alloc_excl && !o_wr_to_mem)
        else $error("writeback attributes wrong");

endmodule

//--- sim/pmtr_walker.sv
// page walker model: presents one translated entry per request
// assumes: request fields change just after a rising clock edge
module pmtr_walker (
    input  wire logic        i_go,
    input  wire logic        i_attr,
    input  wire logic        i_pcd,
    input  wire logic        i_pwt,
    input  wire logic [1:0]  i_lvl,
    output logic             o_valid,
    output logic      [63:0] o_entry
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // entry build
    // ------------------------------------------------------------
    // index bits in place, filler elsewhere, inverted when idle
    always_comb
    begin
        o_valid = i_go;
        o_entry = 64'ha5a5_a5a5_a5a5_a5a5;
        o_entry[3] = i_pwt;
        o_entry[4] = i_pcd;
        // the spot not used by this level holds the wrong value
        o_entry[7] = (i_lvl == 2'h0) ? i_attr : ~i_attr;
        o_entry[12] = (i_lvl == 2'h1) ? i_attr : ~i_attr;
        // upper levels have no attribute bit: both spots garbage
        if (i_lvl[1])
            o_entry = o_entry | 64'h0000_0000_0000_1080;
        if (!i_go)
            o_entry = ~o_entry;
    end
endmodule

//--- sim/page_memory_type_resolver_bench.sv
// bench for the resolver: register port, write checks, lookup, merge
// assumes: one 100 MHz clock; the walker model drives the entry side
module page_memory_type_resolver_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0;
    logic        go = 1'b0, att = 1'b0, page_cache_disable_bit = 1'b0, page_writethrough_bit = 1'b0, ren = 1'b0;
    logic [1:0]  lvl = 2'h0;
    logic [7:0]  addr = 8'h00, rty = 8'h00, attrs;
    logic [31:0] wdata = 32'h0, rdata;
    logic [63:0] entry;
    logic        fault, xv, ev;
    logic [2:0]  et, si;
    int          fail_count = 0, samples_checked = 0;
    always #5 clk = ~clk;
    pmtr_walker u_pmtr_walker (.i_go(go), .i_attr(att), .i_pcd(page_cache_disable_bit), .i_pwt(page_writethrough_bit),
        .i_lvl(lvl), .o_valid(xv), .o_entry(entry));
    // a single resolver: the bench as software keeps one consistent table
    pmtr_resolver u_pmtr_resolver (.i_ref_clk(clk), .i_nrst(nrst), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_fault(fault),
        .i_xlate_valid(xv), .i_entry(entry), .i_level(lvl), .i_range_en(ren),
        .i_range_type(rty), .o_eff_valid(ev), .o_eff_type(et), .o_slot_index(si),
        .o_cacheable(attrs[7]), .o_rd_alloc(attrs[6]), .o_rd_alloc_excl(attrs[5]),
        .o_wr_alloc(attrs[4]), .o_wr_to_mem(attrs[3]), .o_wr_hit_inval(attrs[2]),
        .o_combine_ok(attrs[1]), .o_spec_ok(attrs[0]));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one write; fault pulse looked at in the cycle after
    task automatic wrt(input logic [7:0] a, input logic [31:0] d, input logic f);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
        chk({31'h0, fault}, {31'h0, f});
        // fault pulse must be gone one cycle later
        @(posedge clk);
        #1;
        chk({31'h0, fault}, 32'h0);
    endtask
    // one read; data stands only in the cycle after the strobe
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, e);
    endtask
    // one lookup through the walker, answer one cycle later
    task automatic lk(input logic [4:0] b, input logic [7:0] r);
        @(posedge clk);
        {lvl, att, page_cache_disable_bit, page_writethrough_bit} <= b;
        ren <= 1'b1;
        rty <= r;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        #1;
        chk({31'h0, ev}, 32'h1);
    endtask
    function automatic logic [2:0] emap(input logic [7:0] c);
        case (c)
            pmtr_pkg::T_WC: emap = pmtr_pkg::EFF_WC;
            pmtr_pkg::T_WT: emap = pmtr_pkg::EFF_WT;
            pmtr_pkg::T_WP: emap = pmtr_pkg::EFF_WP;
            pmtr_pkg::T_WB: emap = pmtr_pkg::EFF_WB;
            default: emap = pmtr_pkg::EFF_UC;
        endcase
    endfunction
    // expected effective type of slot code s with range code r
    function automatic logic [2:0] mrg(input logic [7:0] s, input logic [7:0] r);
        logic [2:0] m;
        logic [2:0] cd;
        m = emap(r);
        cd = pmtr_pkg::EFF_CD;
        case (s)
            pmtr_pkg::T_UC: mrg = (m == pmtr_pkg::EFF_UC) ? m : cd;
            pmtr_pkg::T_WEAK_UC: mrg = (m <= pmtr_pkg::EFF_WC) ? m : cd;
            pmtr_pkg::T_WC: mrg = pmtr_pkg::EFF_WC;
            pmtr_pkg::T_WP: mrg = (m == pmtr_pkg::EFF_WC || m == pmtr_pkg::EFF_WT) ? cd :
                (m == pmtr_pkg::EFF_WB) ? pmtr_pkg::EFF_WP : m;
            pmtr_pkg::T_WT: mrg = (m == pmtr_pkg::EFF_UC) ? m :
                (m == pmtr_pkg::EFF_WC || m == pmtr_pkg::EFF_WP) ? cd : pmtr_pkg::EFF_WT;
            default: mrg = m;
        endcase
    endfunction
    // cache attributes, cacheable down to speculation
    function automatic logic [7:0] ax(input logic [2:0] t);
        case (t)
            pmtr_pkg::EFF_WC: ax = 8'h0b;
            pmtr_pkg::EFF_WT: ax = 8'hc8;
            pmtr_pkg::EFF_WP: ax = 8'hcc;
            pmtr_pkg::EFF_WB: ax = 8'hf0;
            default: ax = 8'h08;
        endcase
    endfunction
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        rdc(8'h00, 32'h00070406);
        rdc(8'h04, 32'h00070406);
        rdc(8'h08, 32'h00010000);
        rdc(8'h10, 32'h0);
        wrt(8'h00, 32'h00000002, 1'b1);
        rdc(8'h00, 32'h00070406);
        wrt(8'h04, 32'h00000800, 1'b1);
        rdc(8'h04, 32'h00070406);
        rdc(8'h0c, 32'h1);
        wrt(8'h0c, 32'h1, 1'b0);
        rdc(8'h0c, 32'h0);
        wrt(8'h00, 32'h07060504, 1'b0);
        rdc(8'h00, 32'h07060504);
        wrt(8'h04, 32'h05010406, 1'b0);
        rdc(8'h04, 32'h05010406);
        wrt(8'h04, 32'h00070406, 1'b0);
        wrt(8'h00, 32'h00070406, 1'b0);
    endtask
    // index from level, attribute, cache disable, writethrough
    task automatic t_index;
        logic [7:0] cs [5] = '{8'h36, 8'h6d, 8'hbb, 8'he0, 8'h1b};
        logic [31:0] d;
        foreach (cs[i])
        begin
            lk(cs[i][7:3], pmtr_pkg::T_WB);
            chk({29'h0, si}, {29'h0, cs[i][2:0]});
            d = 32'h00070406 >> (8 * cs[i][1:0]);
            chk({29'h0, et}, {29'h0, mrg(d[7:0], pmtr_pkg::T_WB)});
        end
    endtask
    // every slot code against every range code, then range off
    task automatic t_merge;
        logic [7:0] sc [6] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h06, 8'h07};
        logic [7:0] rc [5] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h06};
        foreach (sc[i])
        begin
            wrt(8'h00, {24'h0, sc[i]}, 1'b0);
            foreach (rc[j])
            begin
                lk(5'h00, rc[j]);
                chk({29'h0, et}, {29'h0, mrg(sc[i], rc[j])});
                chk({24'h0, attrs}, {24'h0, ax(mrg(sc[i], rc[j]))});
            end
            @(posedge clk);
            ren <= 1'b0;
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            #1;
            chk({29'h0, et}, {29'h0, mrg(sc[i], pmtr_pkg::T_UC)});
        end
    endtask
    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (5) @(posedge clk);
        t_regs();
        t_index();
        t_merge();
        report_and_stop();
    end
endmodule
